// ---- design/sac_pkg.sv ----
// Purpose: shared constants and types for the converter control block
// Assumes: block clock of 20 MHz (50 ns period)
// Notes:   all timing figures kept in ns, cycle counts derived below
package sac_pkg;

  // result width and buffering
  localparam int DATA_W     = 18;
  localparam int FIFO_DEPTH = 8;

  // clock and conversion timing, figures in ns
  localparam int CLK_PERIOD_NS = 50;
  localparam int CONV_MIN_NS   = 500;
  localparam int CONV_MAX_NS   = 1300;

  // conversion counter width and derived cycle counts
  localparam int CNT_W = 6;
  // least time rounds up
  localparam logic [CNT_W-1:0] CONV_MIN_CYC =
    CNT_W'((CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // longest time rounds down
  localparam logic [CNT_W-1:0] CONV_MAX_CYC =
    CNT_W'(CONV_MAX_NS / CLK_PERIOD_NS);

  // serial bit counter width, holds up to the busy-bit frame length
  localparam int BIT_W = 5;

  // reset values of the pin view and serial output, and the busy-bit level
  localparam logic PIN_IDLE      = 1'b1;
  localparam logic OUT_OE_N_RST  = 1'b1;
  localparam logic OUT_DATA_RST  = 1'b1;
  localparam logic BUSY_BIT_LVL  = 1'b0;

  // control states
  typedef enum logic [1:0] {
    SAC_ACQ   = 2'b00,  // acquisition, powered down, output released
    SAC_CONV  = 2'b01,  // conversion on the internal clock
    SAC_WAIT  = 2'b10,  // result buffered, waiting for the read to open
    SAC_SHIFT = 2'b11   // result going out on serial-clock falls
  } sac_state_t;

  // the three digital pins that arrive from the host
  typedef struct packed {
    logic convert_start_input;
    logic din;
    logic sclk;
  } sac_pins_t;

endpackage : sac_pkg

// ---- design/sac_sync.sv ----
// Purpose: two-flop synchroniser for asynchronous pin levels
// Assumes: inputs are levels, each bit crossed independently
// Notes:   only the second stage may be read by other logic
module sac_sync #(
  parameter int          W     = 3,
  parameter logic [W-1:0] RST_V = '1
) (
  input  wire logic         i_clock,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // first stage feeds the second stage and nothing else
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      meta_reg <= RST_V;
      sync_reg <= RST_V;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;

endmodule // sac_sync

// ---- design/sac_fifo.sv ----
// Purpose: small synchronous fifo between conversion and readout
// Assumes: single clock, depth a power of two
// Notes:   push and pop in one cycle allowed even when full
module sac_fifo #(
  parameter int W     = 18,
  parameter int DEPTH = 8
) (
  input  wire logic         i_clock,
  input  wire logic         i_rst,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic      [W-1:0] o_out_data
);

  localparam int AW = $clog2(DEPTH);

  // elaboration check: pointers wrap only for power-of-two depths
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least 2");
  end

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_reg, wr_next;
  logic [AW-1:0] rd_reg, rd_next;
  logic [AW:0]   cnt_reg, cnt_next;
  logic          push, pop;

  // valid straight from the fill count, ready also when a pop frees the slot
  assign o_out_valid = (cnt_reg != '0);
  assign o_in_ready  = (cnt_reg != (AW+1)'(DEPTH)) || i_out_ready;
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_data  = mem[rd_reg];

  // pointer and count next values
  always_comb begin
    wr_next  = push ? wr_reg + 1'b1 : wr_reg;
    rd_next  = pop ? rd_reg + 1'b1 : rd_reg;
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // storage has no reset, only written words are ever read
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_reg] <= i_in_data;
    end
  end

endmodule // sac_fifo

// ---- design/sac_ctrl.sv ----
// Purpose: conversion sequencer and serial readout of a SAR converter
// Assumes: pins from the host are asynchronous and pass two flops;
//          the analog core reports done and an offset-binary code
// Notes:   serial clock only moves readout bits, never conversion timing
module sac_ctrl #(
  parameter int DATA_W     = sac_pkg::DATA_W,
  parameter int FIFO_DEPTH = sac_pkg::FIFO_DEPTH
) (
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  input  wire logic              i_convert_start_input,
  input  wire logic              i_serial_in,
  input  wire logic              i_serial_clock,
  input  wire logic              i_core_done,
  input  wire logic [DATA_W-1:0] i_core_code,
  output logic                   o_core_start,
  output logic                   o_sample_connect,
  output logic                   o_powered_down,
  output logic                   o_converting,
  output logic                   o_daisy_mode,
  output logic                   o_busy_bit_enabled,
  output logic                   o_result_ready,
  output logic                   o_serial_out,
  output logic                   o_serial_out_oe_n
);

  localparam int SH_W = DATA_W + 1;

  // the busy frame must fit the bit counter, timing must be ordered
  if (DATA_W < 2 || SH_W >= (1 << sac_pkg::BIT_W)) begin : g_bad_width
    $error("result width does not fit the serial bit counter");
  end
  if (sac_pkg::CONV_MIN_CYC > sac_pkg::CONV_MAX_CYC) begin : g_bad_conv
    $error("minimum conversion time exceeds maximum");
  end
  // the fifo itself refuses non-power-of-two depths, this catches the trivial case
  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("fifo needs at least two words");
  end

  // offset binary from the core to two's complement
  function automatic logic [DATA_W-1:0] to_twos(
    input logic [DATA_W-1:0] code
  );
    to_twos = {~code[DATA_W-1], code[DATA_W-2:0]};
  endfunction

  // frame length in serial falls, one more when the busy bit leads
  function automatic logic [sac_pkg::BIT_W-1:0] frame_len(
    input logic busy
  );
    frame_len = busy ? sac_pkg::BIT_W'(SH_W) : sac_pkg::BIT_W'(DATA_W);
  endfunction

  // pins cross into the block clock through two flops
  sac_pkg::sac_pins_t pins_raw;
  sac_pkg::sac_pins_t pins_s;
  sac_pkg::sac_pins_t pins_prev_reg;
  sac_pkg::sac_pins_t pins_prev_next;

  assign pins_raw.convert_start_input = i_convert_start_input;
  assign pins_raw.din    = i_serial_in;
  assign pins_raw.sclk   = i_serial_clock;

  sac_sync #(
    .W     (3),
    .RST_V ({3{sac_pkg::PIN_IDLE}})
  ) u_sync (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_async (pins_raw),
    .o_sync  (pins_s)
  );

  // fifo between the converter and the serial shifter
  logic              push_valid;
  logic              push_ready;
  logic [DATA_W-1:0] push_data;
  logic              pop_valid;
  logic              pop_ready;
  logic [DATA_W-1:0] pop_data;

  sac_fifo #(
    .W     (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clock     (i_clock),
    .i_rst       (i_rst),
    .i_in_valid  (push_valid),
    .o_in_ready  (push_ready),
    .i_in_data   (push_data),
    .o_out_valid (pop_valid),
    .i_out_ready (pop_ready),
    .o_out_data  (pop_data)
  );

  // control state
  sac_pkg::sac_state_t           state_reg, state_next;
  logic [sac_pkg::CNT_W-1:0]     conv_cnt_reg, conv_cnt_next;
  logic [sac_pkg::BIT_W-1:0]     bit_cnt_reg, bit_cnt_next;
  logic [SH_W-1:0]               shift_reg, shift_next;
  logic                          daisy_reg, daisy_next;
  logic                          busy_en_reg, busy_en_next;
  logic                          dout_reg, dout_next;
  logic                          oe_n_reg, oe_n_next;
  logic                          start_reg, start_next;
  logic                          sel_n_prev_reg, sel_n_prev_next;

  // edges seen on the synchronised pins
  logic cnv_rise;
  logic sclk_fall;
  logic sel_n;
  logic sel_rise;
  logic conv_end;

  assign cnv_rise  = pins_s.convert_start_input && !pins_prev_reg.convert_start_input;
  assign sclk_fall = !pins_s.sclk && pins_prev_reg.sclk;
  // 3-wire ties data-in high, 4-wire holds convert-start high, so the
  // select is low when either pin is low; daisy uses convert-start
  assign sel_n     = daisy_reg ? pins_s.convert_start_input
                               : (pins_s.convert_start_input && pins_s.din);
  assign sel_rise  = sel_n && !sel_n_prev_reg;
  // length set by the core but clamped between the two bounds
  assign conv_end  = ((conv_cnt_reg >= sac_pkg::CONV_MIN_CYC - 1'b1)
                      && i_core_done)
                     || (conv_cnt_reg >= sac_pkg::CONV_MAX_CYC - 1'b1);

  // result enters the fifo at conversion end, recoded on the way
  assign push_data  = to_twos(i_core_code);
  assign push_valid = (state_reg == sac_pkg::SAC_CONV) && conv_end;
  assign pop_ready  = (state_reg == sac_pkg::SAC_WAIT) && pop_valid
                      && (busy_en_reg || !sel_n);

  // timing of one sample, counted in block clock edges:
  //   pin rise at edge 0, seen in the second sync stage at edge 2,
  //   compared against the previous sample in the cycle after it,
  //   so the conversion state and start pulse appear at edge 3.
  // conversion:
  //   the counter starts at zero in the first conversion cycle;
  //   the core may finish the word from the tenth cycle on, and the
  //   twenty-sixth cycle ends it regardless, so the length stays
  //   inside the allowed band even with a silent core.
  //   a full buffer holds the end back instead of losing a word;
  //   the converting flag then stays high for good, as nothing pops while converting.
  // busy decision:
  //   the select level in the last conversion cycle picks the frame
  //   kind; low asks for the leading busy bit, high leaves the line
  //   released until the host lowers the select itself.
  // readout:
  //   every serial-clock fall is found three block clocks after the
  //   pin moves, so the host clock must stay well below the block
  //   clock; a faster host would see bits repeated, not skipped.
  //   the output bit changes only on a detected fall, which keeps
  //   the bit valid on both serial-clock edges for a slow host.
  //   a select rise ends the frame on the next edge whatever the
  //   count, and the remaining bits of that word are dropped.
  // restart:
  //   a convert-start rise in any state but conversion begins a new
  //   sample at once, even in the middle of a frame; from a frame the old
  //   word has left the buffer; from the wait state it is popped and dropped only if the busy bit is set or the select is low in that cycle, else it stays buffered.
  // daisy data:
  //   in daisy mode the data-in level enters the low end of the
  //   shifter on each fall, but the frame ends before those bits reach
  //   the output; in select mode zeros fill in and are never shown.
  // limitation:
  //   only one word waits per frame; further words stay buffered
  //   until the next conversion ends and opens a new read.

  // sequencer next values
  always_comb begin
    state_next      = state_reg;
    conv_cnt_next   = conv_cnt_reg;
    bit_cnt_next    = bit_cnt_reg;
    shift_next      = shift_reg;
    daisy_next      = daisy_reg;
    busy_en_next    = busy_en_reg;
    dout_next       = dout_reg;
    oe_n_next       = oe_n_reg;
    start_next      = 1'b0;
    sel_n_prev_next = sel_n;
    pins_prev_next  = pins_s;

    case (state_reg)
      sac_pkg::SAC_CONV: begin
        // serial clock has no effect here, output stays released
        oe_n_next     = sac_pkg::OUT_OE_N_RST;
        conv_cnt_next = conv_cnt_reg + 1'b1;
        if (conv_end && push_ready) begin
          // a select held low at the end asks for the busy bit
          busy_en_next = !sel_n;
          state_next   = sac_pkg::SAC_WAIT;
        end else if (conv_end) begin
          // full fifo holds the conversion at its end; no pop frees room while converting
          conv_cnt_next = conv_cnt_reg;
        end
      end
      sac_pkg::SAC_WAIT: begin
        if (pop_ready) begin
          bit_cnt_next = '0;
          oe_n_next    = 1'b0;
          if (busy_en_reg) begin
            // busy bit first, acting as the host interrupt
            shift_next = {sac_pkg::BUSY_BIT_LVL, pop_data};
          end else begin
            // select fall opens the frame with the MSB
            shift_next = {pop_data, 1'b0};
          end
          dout_next  = shift_next[SH_W-1];
          state_next = sac_pkg::SAC_SHIFT;
        end
      end
      sac_pkg::SAC_SHIFT: begin
        if (sel_rise) begin
          // select release cuts the frame short
          oe_n_next  = sac_pkg::OUT_OE_N_RST;
          state_next = sac_pkg::SAC_ACQ;
        end else if (sclk_fall) begin
          // serial clock only moves bits out of the shifter
          shift_next   = {shift_reg[SH_W-2:0],
                          daisy_reg & pins_s.din};
          dout_next    = shift_next[SH_W-1];
          bit_cnt_next = bit_cnt_reg + 1'b1;
          if (bit_cnt_next == frame_len(busy_en_reg)) begin
            oe_n_next  = sac_pkg::OUT_OE_N_RST;
            dout_next  = sac_pkg::OUT_DATA_RST;
            state_next = sac_pkg::SAC_ACQ;
          end
        end
      end
      default: begin
        // acquisition: idle until the next convert-start
        oe_n_next = sac_pkg::OUT_OE_N_RST;
      end
    endcase

    // a convert-start rise outside a conversion restarts the sequencer, not the fifo
    if (cnv_rise && state_reg != sac_pkg::SAC_CONV) begin
      daisy_next    = !pins_s.din;
      oe_n_next     = sac_pkg::OUT_OE_N_RST;
      dout_next     = sac_pkg::OUT_DATA_RST;
      conv_cnt_next = '0;
      start_next    = 1'b1;
      state_next    = sac_pkg::SAC_CONV;
    end
  end

  // sequencer registers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_reg      <= sac_pkg::SAC_ACQ;
      conv_cnt_reg   <= '0;
      bit_cnt_reg    <= '0;
      shift_reg      <= '0;
      daisy_reg      <= 1'b0;
      busy_en_reg    <= 1'b0;
      dout_reg       <= sac_pkg::OUT_DATA_RST;
      oe_n_reg       <= sac_pkg::OUT_OE_N_RST;
      start_reg      <= 1'b0;
      sel_n_prev_reg <= sac_pkg::PIN_IDLE;
      pins_prev_reg  <= {3{sac_pkg::PIN_IDLE}};
    end else begin
      state_reg      <= state_next;
      conv_cnt_reg   <= conv_cnt_next;
      bit_cnt_reg    <= bit_cnt_next;
      shift_reg      <= shift_next;
      daisy_reg      <= daisy_next;
      busy_en_reg    <= busy_en_next;
      dout_reg       <= dout_next;
      oe_n_reg       <= oe_n_next;
      start_reg      <= start_next;
      sel_n_prev_reg <= sel_n_prev_next;
      pins_prev_reg  <= pins_prev_next;
    end
  end

  // status views, all decoded from registered state
  assign o_core_start       = start_reg;
  // sampling switch open for the whole conversion
  assign o_sample_connect   = (state_reg != sac_pkg::SAC_CONV);
  assign o_powered_down     = (state_reg != sac_pkg::SAC_CONV);
  assign o_converting       = (state_reg == sac_pkg::SAC_CONV);
  assign o_daisy_mode       = daisy_reg;
  assign o_busy_bit_enabled = busy_en_reg;
  // readable only once a result sits in the buffer
  assign o_result_ready     = pop_valid;
  assign o_serial_out       = dout_reg;
  assign o_serial_out_oe_n  = oe_n_reg;

endmodule // sac_ctrl

// ---- test/sac_ctrl_asserts.sv ----
// Purpose: port-level checks of the converter control block
// Assumes: one clock domain, synchronous reset
// Notes:   conversion length kept in a small helper counter
module sac_ctrl_asserts (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_serial_in,
  input wire logic o_core_start,
  input wire logic o_sample_connect,
  input wire logic o_powered_down,
  input wire logic o_converting,
  input wire logic o_daisy_mode,
  input wire logic o_busy_bit_enabled,
  input wire logic o_result_ready,
  input wire logic o_serial_out,
  input wire logic o_serial_out_oe_n
);
  logic [5:0] len_reg;
  logic [5:0] len_next;

  // conversion cycles, saturating so a stall cannot wrap it
  always_comb begin
    len_next = len_reg;
    if (o_core_start) len_next = 6'h01;
    else if (o_converting && len_reg != 6'h3f) len_next = len_reg + 6'h01;
  end
  always_ff @(posedge i_clock) begin
    if (i_rst) len_reg <= 6'h00;
    else len_reg <= len_next;
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  property p_start; $rose(o_converting) |-> o_core_start; endproperty
  a_start: assert property (p_start)
    else $error("conversion began without start pulse");
  property p_hiz;
    o_converting |-> o_serial_out_oe_n && !o_sample_connect;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("output driven or inputs tied while converting");
  property p_acq; !o_converting |-> o_powered_down && o_sample_connect;
  endproperty
  a_acq: assert property (p_acq)
    else $error("not powered down or not reconnected after conversion");
  property p_min; $fell(o_converting) |-> len_reg >= 6'h0a; endproperty
  a_min: assert property (p_min)
    else $error("conversion shorter than minimum");
  property p_max;
    o_converting && !o_core_start && !o_result_ready |-> len_reg <= 6'h19;
  endproperty
  a_max: assert property (p_max)
    else $error("conversion longer than maximum");
  property p_mode; o_core_start |-> o_daisy_mode == !$past(i_serial_in, 3);
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode does not follow data-in at start");
  property p_pulse; o_core_start |=> !o_core_start && o_converting;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("start pulse too long or conversion dropped");
  property p_ready; $fell(o_converting) |-> o_result_ready; endproperty
  a_ready: assert property (p_ready)
    else $error("no result after conversion end");
  property p_busy; $fell(o_converting) && o_busy_bit_enabled
    |=> !o_serial_out_oe_n && !o_serial_out; endproperty
  a_busy: assert property (p_busy)
    else $error("busy bit not driven low after conversion");

  // main scenarios reached
  c_daisy: cover property (o_core_start ##1 o_daisy_mode);
  c_busy: cover property ($fell(o_serial_out_oe_n) && o_busy_bit_enabled);
  c_rel: cover property (!o_serial_out_oe_n ##1 o_serial_out_oe_n);
endmodule // sac_ctrl_asserts

bind sac_ctrl sac_ctrl_asserts i_chk (
  .i_clock(i_clock), .i_rst(i_rst), .i_serial_in(i_serial_in),
  .o_core_start(o_core_start), .o_sample_connect(o_sample_connect),
  .o_powered_down(o_powered_down), .o_converting(o_converting),
  .o_daisy_mode(o_daisy_mode), .o_busy_bit_enabled(o_busy_bit_enabled),
  .o_result_ready(o_result_ready), .o_serial_out(o_serial_out),
  .o_serial_out_oe_n(o_serial_out_oe_n));

// ---- test/sac_host_model.sv ----
// Purpose: serial host driving convert-start, data-in and serial clock
// Assumes: pull-up on the serial line, serial clock idles high
// Notes:   serial clock runs only inside frames and pulse bursts
module sac_host_model (
  input  wire logic i_clock,
  input  wire logic i_serial_out,
  input  wire logic i_serial_out_oe_n,
  output logic      o_convert_start_input,
  output logic      o_din,
  output logic      o_sclk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic dout_w;

  // released line floats up to the pull-up level
  assign dout_w = i_serial_out_oe_n ? 1'b1 : i_serial_out;
  initial begin
    o_convert_start_input = 1'b1;
    o_din    = 1'b1;
    o_sclk   = 1'b1;
  end

  // convert-start rise, data-in held around it to pick the mode
  task automatic start(input logic din_lvl, input logic drop);
    @(posedge i_clock) #2;
    o_convert_start_input = 1'b0;
    o_din    = din_lvl;
    repeat (4) @(posedge i_clock);
    #2 o_convert_start_input = 1'b1;
    repeat (2) @(posedge i_clock);
    #2 o_convert_start_input = ~drop; // low at the end asks for the busy bit
    repeat (2) @(posedge i_clock);
    #2 o_din = 1'b1;
  endtask

  // stray serial clock pulses, off phase with the block clock
  task automatic pulse(input int n);
    #133;
    repeat (n) begin
      #200 o_sclk = 1'b0;
      #200 o_sclk = 1'b1;
    end
  endtask

  // one read after the conversion is done, bit taken before each fall
  task automatic frame(input int n, input logic by_din,
                       output logic [18:0] q, output logic rel);
    q = '0;
    @(posedge i_clock) #2;
    if (by_din) o_din = 1'b0;
    else o_convert_start_input = 1'b0;
    #133;
    for (int i = n - 1; i >= 0; i--) begin
      #200 q[i] = dout_w;
      o_sclk = 1'b0;
      #200 o_sclk = 1'b1;
    end
    #400 rel = i_serial_out_oe_n;
    @(posedge i_clock) #2;
    if (by_din) o_din = 1'b1;
    else o_convert_start_input = 1'b1;
  endtask
endmodule // sac_host_model

// ---- test/sac_ctrl_tb_top.sv ----
// Purpose: self-checking bench for the converter control block
// Assumes: 20 MHz block clock, host model on the serial side
// Notes:   analog core stood in by a done delay and a fixed code
module sac_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                       i_clock, i_rst, cs, di, sck, done;
  logic [sac_pkg::DATA_W-1:0] code;
  logic                       cst, sc, pd, cv, dm, be, rdy, so, oen, rel;
  logic [18:0]                q;
  int                         err_count, comparisons, done_at, cnt, clen;

  sac_ctrl i_dut (
    .i_clock(i_clock), .i_rst(i_rst), .i_convert_start_input(cs),
    .i_serial_in(di), .i_serial_clock(sck), .i_core_done(done),
    .i_core_code(code), .o_core_start(cst), .o_sample_connect(sc),
    .o_powered_down(pd), .o_converting(cv), .o_daisy_mode(dm),
    .o_busy_bit_enabled(be), .o_result_ready(rdy), .o_serial_out(so),
    .o_serial_out_oe_n(oen));
  sac_host_model i_host (
    .i_clock(i_clock), .i_serial_out(so), .i_serial_out_oe_n(oen),
    .o_convert_start_input(cs), .o_din(di), .o_sclk(sck));

  // 50 ns block clock
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  // core stand-in: done after done_at cycles; conversion length count
  always @(posedge i_clock) begin
    #2;
    cnt = cst ? 0 : cnt + 1;
    done = (cnt >= done_at);
    clen = cst ? 1 : clen + int'(cv);
  end

  task automatic check(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // bounded wait until the conversion has left a result
  task automatic wait_conv();
    int n;
    n = 0;
    while ((cv || !rdy) && n < 200) begin
      @(posedge i_clock) #2;
      n++;
    end
    if (n == 200) begin
      err_count++;
      end_of_test();
    end
  endtask

  // a convert-start rise that closes a frame also starts a conversion
  task automatic drain(input logic [17:0] exp);
    wait_conv();
    check("mode", dm, 0);
    i_host.frame(18, 1'b1, q, rel);
    check("next_word", q[17:0], exp);
  endtask

  // four-wire select, no busy bit, shortest conversion, lowest code
  task automatic t_cs4();
    done_at = 0;
    code = 18'h00000;
    i_host.start(1'b1, 1'b0);
    wait_conv();
    check("conv_len", clen, 10);
    check("daisy", dm, 0);
    check("busy_en", be, 0);
    i_host.frame(18, 1'b1, q, rel);
    check("word", q[17:0], 18'h20000);
    check("release", rel, 1);
  endtask

  // daisy mode, core never done, serial clock toggled mid-conversion
  task automatic t_daisy();
    done_at = 1000;
    code = 18'h3ffff;
    i_host.start(1'b0, 1'b0);
    i_host.pulse(2);
    wait_conv();
    check("conv_len", clen, 26);
    check("daisy", dm, 1);
    i_host.frame(18, 1'b0, q, rel);
    check("word", q[17:0], 18'h1ffff);
    check("release", rel, 1);
    drain(18'h1ffff);
  endtask

  // three-wire select held low through conversion: busy bit leads
  task automatic t_cs3_busy();
    done_at = 3;
    code = 18'h2a5c3;
    i_host.start(1'b1, 1'b1);
    wait_conv();
    check("busy_en", be, 1);
    @(posedge i_clock) #2;
    check("busy_bit", {oen, so}, 2'b00);
    i_host.frame(19, 1'b0, q, rel);
    check("word", q, 19'h0a5c3);
    check("release", rel, 1);
    drain(18'h0a5c3);
  endtask

  // daisy mode with busy bit, frame cut short by select rising
  task automatic t_abort();
    done_at = 0;
    code = 18'h15555;
    i_host.start(1'b0, 1'b1);
    wait_conv();
    check("daisy_busy", {dm, be}, 2'b11);
    i_host.frame(5, 1'b0, q, rel);
    check("head", q[4:0], 5'b01101);
    check("held", rel, 0);
    repeat (5) @(posedge i_clock);
    check("abort", oen, 1);
    drain(18'h35555);
  endtask

  // reset, then four host variant kinds in turn
  initial begin
    i_rst = 1'b1;
    done = 1'b0;
    code = '0;
    err_count = 0;
    comparisons = 0;
    cnt = 0;
    clen = 0;
    done_at = 0;
    repeat (10) @(posedge i_clock);
    #2 i_rst = 1'b0;
    check("idle", {oen, cv, rdy}, 3'b100);
    t_cs4();
    t_daisy();
    t_cs3_busy();
    t_abort();
    end_of_test();
  end
endmodule // sac_ctrl_tb_top
